// ===== hdl/pcf_forwarder.sv
// Configuration-cycle forwarder of the hub-to-PCI bridge.
//
// Behaviour
// RULE1: One-to-clear bits read back; writing 1 clears, writing 0 keeps.
// RULE2: Read-only writes and write-only reads do nothing; shared address splits.
// RULE3: Reset loads every register with its default value.
// RULE4: Functions 1-6 can each be disabled and then ignore all config access.
// RULE5: Device claims device 30 bridge and device 31 functions, function 4 reserved.
// RULE6: Up to 8 functions each with 256 byte registers.
// RULE7: Only configuration mechanism 1 is supported.
// RULE8: Non-zero bus compared with secondary and subordinate bus numbers.
// RULE9: Type 0 cycles from the hub link run on PCI, then reclaimed.
// RULE10: Type 0 for device 30 sets AD14, device 31 sets AD15.
// RULE11: Type 0 for other devices drives AD[31:11] zero.
// RULE12: Every generated PCI config access is one doubleword.
// RULE13: Bus matching attached PCI bus gives Type 0, converting Type 1.
// RULE14: Targets behind an external bridge get Type 1 on PCI.
// RULE15: Conversion sets only AD[16+device] for devices 0 to 15.
// RULE16: Conversion drives AD[15:11] zero.
// RULE17: Conversion passes AD[10:1] and forces AD0 zero.
// RULE18: Software preserves and masks reserved bits.
// RULE19: Software avoids writing reserved locations above offset 3Fh.
// RULE20: Conversion for devices 16 to 31 sets no upper address bit.
`timescale 1ns/10ps
`include "pcf_defs.svh"
module pcf_forwarder (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Upstream request, mechanism 1 already decoded by the host side
    input wire logic req_valid_in,
    input wire pcf_pkg::pcf_req_type req_in,
    // Static strap inputs from pins
    input wire logic [5:0] func_disable_in,
    // Local event that sets the one-to-clear status bit
    input wire logic status_event_in,
    // PCI side: single doubleword cycle request and completion
    output pcf_pkg::pcf_pci_type pci_out,
    output logic pci_start_out,
    input wire logic pci_done_in,
    input wire logic [31:0] pci_rdata_in,
    // Upstream completion
    output logic cpl_valid_out,
    output logic [31:0] cpl_rdata_out,
    output logic cpl_claimed_out,
    // Bridge bus numbers for observation
    output logic [7:0] sec_bus_out,
    output logic [7:0] sub_bus_out
);
    // ==========================================================
    // Register offsets within the bridge function
    localparam logic [7:0] OFF_STATUS = `PCF_OFF_STATUS;
    localparam logic [7:0] OFF_BUSNUM = `PCF_OFF_BUSNUM;
    localparam logic [7:0] OFF_DISABLE = `PCF_OFF_DISABLE;
    localparam logic [7:0] OFF_SCRATCH = `PCF_OFF_SCRATCH;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PCI = 2'b01,
        ST_DONE = 2'b10
    } pcf_state_type;

    // ==========================================================
    // Pin synchronisers
    logic [5:0] dis_meta_q;
    logic [5:0] dis_sync_q;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dis_meta_q <= 6'h00;
            dis_sync_q <= 6'h00;
        end else begin
            dis_meta_q <= func_disable_in;
            dis_sync_q <= dis_meta_q;
        end
    end

    // ==========================================================
    // Registers
    logic [7:0] sec_bus_q;
    logic [7:0] sub_bus_q;
    logic [5:0] func_dis_q;
    logic err_sts_q;
    logic [31:0] scratch_q;
    logic [31:0] wr_only_q;
    pcf_state_type state_q;
    pcf_pkg::pcf_req_type req_q;
    pcf_pkg::pcf_dest_type dest_q;

    pcf_pkg::pcf_dest_type dest_w;
    pcf_pkg::pcf_pci_type pci_w;

    pcf_addr_xlate u_xlate (
        .req_in(req_q),
        .sec_bus_in(sec_bus_q),
        .sub_bus_in(sub_bus_q),
        .dest_out(dest_w),
        .pci_out(pci_w)
    );

    // Function present: bridge fn0, device 31 fns 0-3,5,6 unless disabled.
    function automatic logic func_present(input logic [4:0] dev, input logic [2:0] fn,
                                          input logic [5:0] dis);
        logic p;
        p = 1'b0;
        if (dev == `PCF_BRIDGE_DEV) begin
            p = (fn == 3'h0); // RULE5
        end else if (dev == `PCF_FUNC_DEV) begin
            if (fn == 3'h0) begin
                p = 1'b1;
            end else if (fn == `PCF_RESERVED_FUNC || fn == 3'h7) begin
                p = 1'b0; // RULE5
            end else begin
                p = !dis[fn - 3'h1]; // RULE4
            end
        end
        return p;
    endfunction

    logic is_local_w;
    logic is_bridge_w;
    logic reg_wr_w;
    assign is_local_w = func_present(req_q.dev, req_q.func, func_dis_q | dis_sync_q);
    assign is_bridge_w = (req_q.dev == `PCF_BRIDGE_DEV) && (req_q.func == 3'h0);
    assign reg_wr_w = (state_q == ST_PCI) && pci_done_in && dest_q == pcf_pkg::PCF_DEST_LOCAL
                      && is_bridge_w && req_q.write;

    // ==========================================================
    // Cycle sequencer
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= ST_IDLE;
            req_q <= '0;
            dest_q <= pcf_pkg::PCF_DEST_NONE;
            pci_start_out <= 1'b0;
            pci_out <= '0;
        end else begin
            pci_start_out <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (req_valid_in) begin
                        req_q <= req_in; // RULE7
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // Translation settled from the latched request.
                    dest_q <= dest_w;
                    pci_out <= pci_w; // RULE12
                    pci_start_out <= (dest_w != pcf_pkg::PCF_DEST_NONE);
                    state_q <= (dest_w != pcf_pkg::PCF_DEST_NONE) ? ST_PCI : ST_IDLE;
                end
                ST_PCI: begin
                    if (pci_done_in) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Completion and local read mux
    function automatic logic [31:0] local_read(input logic [7:0] off, input logic [7:0] sb,
                                               input logic [7:0] ub, input logic [5:0] fd,
                                               input logic es, input logic [31:0] sc);
        logic [31:0] r;
        r = 32'h0;
        case (off)
            OFF_STATUS: r = {es, 31'h0};
            OFF_BUSNUM: r = {8'h00, ub, sb, 8'h00};
            OFF_DISABLE: r = {26'h0, fd};
            // Read reaches the scratch word, write reaches the write-only word.
            OFF_SCRATCH: r = sc; // RULE2
            default: r = 32'h0;
        endcase
        return r;
    endfunction

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cpl_valid_out <= 1'b0;
            cpl_rdata_out <= 32'h0;
            cpl_claimed_out <= 1'b0;
        end else begin
            cpl_valid_out <= 1'b0;
            if ((state_q == ST_DONE && dest_w == pcf_pkg::PCF_DEST_NONE) ||
                (state_q == ST_PCI && pci_done_in)) begin
                cpl_valid_out <= 1'b1;
                cpl_claimed_out <= 1'b0;
                cpl_rdata_out <= 32'hffff_ffff;
                if (state_q == ST_PCI && dest_q != pcf_pkg::PCF_DEST_LOCAL) begin
                    cpl_claimed_out <= 1'b1;
                    cpl_rdata_out <= req_q.write ? 32'h0 : pci_rdata_in;
                end else if (state_q == ST_PCI && is_local_w) begin
                    // Reclaimed locally; absent functions read all ones.
                    cpl_claimed_out <= 1'b1; // RULE9 RULE4
                    cpl_rdata_out <= (req_q.write || !is_bridge_w) ? 32'h0 :
                        local_read({req_q.reg_off[7:2], 2'b00}, sec_bus_q, sub_bus_q,
                                   func_dis_q, err_sts_q, scratch_q);
                end
            end
        end
    end

    // ==========================================================
    // Bridge configuration registers
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sec_bus_q <= `PCF_SEC_BUS_RST; // RULE3
            sub_bus_q <= `PCF_SUB_BUS_RST; // RULE3
            func_dis_q <= `PCF_FUNC_DIS_RST; // RULE3
            wr_only_q <= `PCF_WORD_RST; // RULE3
        end else if (reg_wr_w) begin
            case ({req_q.reg_off[7:2], 2'b00})
                OFF_BUSNUM: begin
                    if (req_q.byte_en[1]) sec_bus_q <= req_q.wdata[15:8];
                    if (req_q.byte_en[2]) sub_bus_q <= req_q.wdata[23:16];
                end
                OFF_DISABLE: begin
                    if (req_q.byte_en[0]) func_dis_q <= req_q.wdata[5:0];
                end
                OFF_SCRATCH: wr_only_q <= req_q.wdata; // RULE2
                default: ;
            endcase
        end
    end

    // Scratch word takes the last write-only value with its 16-bit halves swapped, one cycle later.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            scratch_q <= `PCF_WORD_RST; // RULE3
        end else begin
            scratch_q <= {wr_only_q[15:0], wr_only_q[31:16]};
        end
    end

    // One-to-clear status; a new event wins over a same-cycle clear.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            err_sts_q <= `PCF_STS_RST; // RULE3
        end else if (status_event_in) begin
            err_sts_q <= 1'b1;
        end else if (reg_wr_w && {req_q.reg_off[7:2], 2'b00} == OFF_STATUS &&
                     req_q.byte_en[3] && req_q.wdata[31]) begin
            err_sts_q <= 1'b0; // RULE1
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sec_bus_out <= `PCF_SEC_BUS_RST;
            sub_bus_out <= `PCF_SUB_BUS_RST;
        end else begin
            sec_bus_out <= sec_bus_q;
            sub_bus_out <= sub_bus_q;
        end
    end

    // ==========================================================
    // Checks
    status_clear_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE1
        (reg_wr_w && {req_q.reg_off[7:2], 2'b00} == OFF_STATUS && req_q.byte_en[3]
         && !req_q.wdata[31] && err_sts_q) |=> err_sts_q)
        else $error("status bit cleared by a zero write");
    type0_dev30_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE10
        (pci_start_out && !pci_out.type1 && dest_q == pcf_pkg::PCF_DEST_LOCAL
         && req_q.dev == `PCF_BRIDGE_DEV) |-> pci_out.addr[31:11] == 21'h000008)
        else $error("device 30 idsel wrong");
    type0_other_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE11
        (pci_start_out && dest_q == pcf_pkg::PCF_DEST_LOCAL && req_q.dev < 5'h1e)
        |-> pci_out.addr[31:11] == 21'h0)
        else $error("type 0 upper bits not zero");
    conv_onehot_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE15
        (pci_start_out && dest_q == pcf_pkg::PCF_DEST_PCI0 && !req_q.dev[4])
        |-> $onehot(pci_out.addr[31:16]))
        else $error("conversion idsel not one-hot");
    conv_low_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE16
        (pci_start_out && dest_q == pcf_pkg::PCF_DEST_PCI0)
        |-> pci_out.addr[15:11] == 5'h0 && pci_out.addr[0] == 1'b0)
        else $error("conversion low bits wrong");
    conv_high_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE20
        (pci_start_out && dest_q == pcf_pkg::PCF_DEST_PCI0 && req_q.dev[4])
        |-> pci_out.addr[31:16] == 16'h0)
        else $error("high device selected a target");
    type1_range_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE14
        (pci_start_out && pci_out.type1) |-> req_q.bus > sec_bus_q && req_q.bus <= sub_bus_q)
        else $error("type 1 outside bus range");
    disabled_quiet_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE4
        (state_q == ST_PCI && pci_done_in && dest_q == pcf_pkg::PCF_DEST_LOCAL
         && req_q.dev == `PCF_FUNC_DEV && req_q.func == 3'h1 && (func_dis_q[0] || dis_sync_q[0]))
        |=> cpl_valid_out && !cpl_claimed_out)
        else $error("disabled function answered");
    type0_dev31_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE10
        (pci_start_out && !pci_out.type1 && dest_q == pcf_pkg::PCF_DEST_LOCAL
         && req_q.dev == `PCF_FUNC_DEV) |-> pci_out.addr[31:11] == 21'h000010)
        else $error("device 31 idsel wrong");
    type1_format_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE14
        (pci_start_out && pci_out.type1) |-> pci_out.addr[1:0] == 2'b01)
        else $error("type 1 address format wrong");
    start_single_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE12
        pci_start_out |=> !pci_start_out)
        else $error("back to back cycle starts");
endmodule

// ===== hdl/pcf_defs.svh
// Constants for the configuration-cycle forwarder.
`ifndef PCF_DEFS_SVH
`define PCF_DEFS_SVH
`define PCF_BRIDGE_DEV 5'h1e
`define PCF_FUNC_DEV 5'h1f
`define PCF_DEV30_ADBIT 14
`define PCF_DEV31_ADBIT 15
`define PCF_IDSEL_BASE 16
`define PCF_FUNC_COUNT 4'h8
`define PCF_REG_COUNT 9'h100
`define PCF_RESERVED_FUNC 3'h4
`define PCF_SEC_BUS_RST 8'h00
`define PCF_SUB_BUS_RST 8'h00
`define PCF_FUNC_DIS_RST 6'h00
`define PCF_OFF_STATUS 8'h04
`define PCF_OFF_BUSNUM 8'h18
`define PCF_OFF_DISABLE 8'h40
`define PCF_OFF_SCRATCH 8'h44
`define PCF_WORD_RST 32'h0
`define PCF_STS_RST 1'b0
`endif

// ===== hdl/pcf_pkg.sv
// Types for the configuration-cycle forwarder.
package pcf_pkg;
    typedef struct packed {
        logic write;
        logic type1;
        logic [7:0] bus;
        logic [4:0] dev;
        logic [2:0] func;
        logic [7:0] reg_off;
        logic [3:0] byte_en;
        logic [31:0] wdata;
    } pcf_req_type;

    typedef enum logic [1:0] {
        PCF_DEST_NONE = 2'b00,
        PCF_DEST_LOCAL = 2'b01,
        PCF_DEST_PCI0 = 2'b10,
        PCF_DEST_PCI1 = 2'b11
    } pcf_dest_type;

    typedef struct packed {
        logic write;
        logic type1;
        logic [31:0] addr;
        logic [3:0] byte_en;
        logic [31:0] wdata;
    } pcf_pci_type;
endpackage

// ===== hdl/pcf_addr_xlate.sv
// Address translation of configuration cycles onto PCI address lines.
`timescale 1ns/10ps
`include "pcf_defs.svh"
module pcf_addr_xlate (
    // Request and bridge bus range
    input wire pcf_pkg::pcf_req_type req_in,
    input wire logic [7:0] sec_bus_in,
    input wire logic [7:0] sub_bus_in,
    // Result
    output pcf_pkg::pcf_dest_type dest_out,
    output pcf_pkg::pcf_pci_type pci_out
);
    logic [31:0] a;
    always_comb begin
        a = 32'h0;
        dest_out = pcf_pkg::PCF_DEST_NONE;
        if (!req_in.type1 || req_in.bus == 8'h00) begin
            // Type 0 is run on PCI then reclaimed locally.
            dest_out = pcf_pkg::PCF_DEST_LOCAL; // RULE9
            if (req_in.dev == `PCF_BRIDGE_DEV) begin
                a[`PCF_DEV30_ADBIT] = 1'b1; // RULE10
            end else if (req_in.dev == `PCF_FUNC_DEV) begin
                a[`PCF_DEV31_ADBIT] = 1'b1; // RULE10
            end
            // Other device numbers leave AD[31:11] at zero.
            a[10:8] = req_in.func; // RULE11
            a[7:2] = req_in.reg_off[7:2]; // RULE6
        end else if (req_in.bus == sec_bus_in) begin
            dest_out = pcf_pkg::PCF_DEST_PCI0; // RULE8 RULE13
            if (!req_in.dev[4]) begin
                a[`PCF_IDSEL_BASE + {28'h0, req_in.dev[3:0]}] = 1'b1; // RULE15
            end
            // Devices 16..31 select nothing; AD[15:11] stay zero.
            a[10:1] = {req_in.func, req_in.reg_off[7:2], 1'b0}; // RULE16 RULE17 RULE20
            a[0] = 1'b0; // RULE17
        end else if (req_in.bus > sec_bus_in && req_in.bus <= sub_bus_in) begin
            dest_out = pcf_pkg::PCF_DEST_PCI1; // RULE8 RULE14
            a = {8'h00, req_in.bus, req_in.dev, req_in.func, req_in.reg_off[7:2], 2'b01};
        end
        pci_out.write = req_in.write;
        pci_out.type1 = (dest_out == pcf_pkg::PCF_DEST_PCI1);
        pci_out.addr = a;
        pci_out.byte_en = req_in.byte_en; // RULE12
        pci_out.wdata = req_in.wdata;
    end
endmodule

// ===== test/pcf_pci_target.sv
// Behavioural PCI target that answers the forwarder's configuration cycles.
`timescale 1ns/10ps
module pcf_pci_target (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Cycle from the bridge and answer pacing
    input wire logic start_in,
    input wire pcf_pkg::pcf_pci_type pci_in,
    input wire logic [3:0] wait_in,
    // Answer
    output logic done_out,
    output logic [31:0] rdata_out
);
    logic done_q = 1'b0;
    logic [31:0] rdata_q = 32'h0;
    logic busy_q = 1'b0;
    logic [3:0] cnt_q = 4'h0;
    logic [31:0] addr_q = 32'h0;

    assign done_out = done_q;
    assign rdata_out = rdata_q;

    // Read data changes every cycle outside the answer, so a late sample shows up.
    always @(negedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            rdata_q <= ~rdata_q ^ {28'h0, cnt_q};
            if (start_in) begin
                busy_q <= 1'b1;
                cnt_q <= wait_in;
                addr_q <= pci_in.addr;
            end else if (busy_q && cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end else if (busy_q) begin
                // One answer per cycle: each access is a single doubleword.
                busy_q <= 1'b0;
                done_q <= 1'b1;
                rdata_q <= addr_q ^ 32'ha5a5_5a5a;
            end
        end
    end
endmodule

// ===== test/test_pci_config_cycle_forwarder.sv
// Self-checking bench for the configuration-cycle forwarder.
`timescale 1ns/10ps
`include "pcf_defs.svh"
module test_pci_config_cycle_forwarder;
    // ========
    // Signals
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic req_valid_in = 1'b0;
    pcf_pkg::pcf_req_type req_in = '0;
    logic [5:0] func_disable_in = 6'h00;
    logic status_event_in = 1'b0;
    pcf_pkg::pcf_pci_type pci_out;
    logic pci_start_out;
    logic pci_done_in;
    logic [31:0] pci_rdata_in;
    logic cpl_valid_out;
    logic [31:0] cpl_rdata_out;
    logic cpl_claimed_out;
    logic [7:0] sec_bus_out;
    logic [7:0] sub_bus_out;
    logic [3:0] wait_v = 4'h0;
    logic [3:0] be_v = 4'hf;
    logic st_v;
    logic cl_v;
    logic [31:0] rd_v;
    pcf_pkg::pcf_pci_type seen_v;
    int error_cnt = 0;
    int check_count = 0;
    int cycle_cnt = 0;

    always #4 clk_in = ~clk_in;

    pcf_forwarder dut (.clk_in, .nrst_in, .req_valid_in, .req_in, .func_disable_in,
        .status_event_in, .pci_out, .pci_start_out, .pci_done_in, .pci_rdata_in,
        .cpl_valid_out, .cpl_rdata_out, .cpl_claimed_out, .sec_bus_out, .sub_bus_out);
    pcf_pci_target target (.clk_in, .nrst_in, .start_in(pci_start_out), .pci_in(pci_out),
        .wait_in(wait_v), .done_out(pci_done_in), .rdata_out(pci_rdata_in));

    // ========
    // Checking and transfer tasks
    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    always @(posedge clk_in) begin
        cycle_cnt++;
        if (cycle_cnt == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    // Called at a falling edge; returns at the falling edge that shows the completion.
    task automatic xfer(input logic w, input logic t1, input logic [7:0] bus,
            input logic [4:0] dev, input logic [2:0] fn, input logic [7:0] off,
            input logic [31:0] wd);
        int n;
        req_in = '{w, t1, bus, dev, fn, off, be_v, wd};
        req_valid_in = 1'b1;
        st_v = 1'b0;
        @(negedge clk_in);
        req_valid_in = 1'b0;
        for (n = 0; n < 40 && cpl_valid_out !== 1'b1; n++) begin
            if (pci_start_out === 1'b1) begin
                st_v = 1'b1;
                seen_v = pci_out;
            end
            @(negedge clk_in);
        end
        check(32'(n < 40), 32'h1);
        rd_v = cpl_rdata_out;
        cl_v = cpl_claimed_out;
    endtask

    task automatic wr(input logic [7:0] off, input logic [31:0] wd);
        xfer(1'b1, 1'b0, 8'h00, `PCF_BRIDGE_DEV, 3'h0, off, wd);
    endtask

    task automatic rd(input logic [7:0] off);
        xfer(1'b0, 1'b0, 8'h00, `PCF_BRIDGE_DEV, 3'h0, off, 32'h0);
    endtask

    // ========
    // Expectations; the secondary bus is set to 1 and the subordinate to 4
    function automatic logic [31:0] exp_addr(logic t1, logic [7:0] bus, logic [4:0] dev,
            logic [2:0] fn, logic [7:0] off);
        logic [31:0] a;
        a = {21'h0, fn, off[7:2], 2'b00};
        if (t1 && bus > 8'h01)
            a = {8'h00, bus, dev, fn, off[7:2], 2'b01};
        else if (t1 && dev < 5'h10)
            a[16 + dev] = 1'b1;
        else if (!t1 && dev == `PCF_BRIDGE_DEV)
            a[14] = 1'b1;
        else if (!t1 && dev == `PCF_FUNC_DEV)
            a[15] = 1'b1;
        return a;
    endfunction

    function automatic logic exp_claim(logic [4:0] dev, logic [2:0] fn, logic [5:0] dis);
        if (dev == `PCF_BRIDGE_DEV)
            return fn == 3'h0;
        if (dev != `PCF_FUNC_DEV || fn == 3'h4 || fn == 3'h7)
            return 1'b0;
        return fn == 3'h0 || !dis[fn - 3'h1];
    endfunction

    // ========
    // Main sequence
    initial begin
        logic [31:0] r;
        logic [1:0] cat;
        logic [7:0] bus;
        logic [5:0] dis;
        logic ex;
        logic [31:0] ea;
        int i;
        int k;
        int f;
        r = $urandom(32'h5d01e344);
        repeat (10) @(negedge clk_in);
        check(32'({pci_start_out, cpl_valid_out, sec_bus_out, sub_bus_out}), 32'h0);
        nrst_in = 1'b1;
        @(negedge clk_in);
        // Reserved bits are masked off before comparing.
        rd(8'h18);
        check(rd_v & 32'h00ff_ff00, 32'h0);
        rd(8'h04);
        check(rd_v & 32'h8000_0000, 32'h0);
        rd(8'h40);
        check(rd_v & 32'h0000_003f, 32'h0);
        wr(8'h18, 32'h0004_0100);
        check(seen_v.addr, 32'h0000_4018);
        check(seen_v.wdata, 32'h0004_0100);
        check(32'(seen_v.write), 32'h1);
        // The bus number copies follow the registers one clock later.
        @(negedge clk_in);
        check({16'h0, sec_bus_out, sub_bus_out}, 32'h0000_0104);
        status_event_in = 1'b1;
        @(negedge clk_in);
        status_event_in = 1'b0;
        rd(8'h04);
        check(32'(rd_v[31]), 32'h1);
        wr(8'h04, 32'h0);
        rd(8'h04);
        check(32'(rd_v[31]), 32'h1);
        wr(8'h04, 32'h8000_0000);
        rd(8'h04);
        check(32'(rd_v[31]), 32'h0);
        wr(8'h44, 32'h1234_abcd);
        rd(8'h44);
        check(rd_v, 32'habcd_1234);
        // Pin disables one at a time, then none, then the register path alone.
        for (k = 0; k < 8; k++) begin
            func_disable_in = (k < 6) ? 6'(1 << k) : 6'h00;
            dis = (k == 7) ? 6'h04 : func_disable_in;
            if (k == 7)
                wr(8'h40, 32'h0000_0004);
            repeat (4) @(negedge clk_in);
            for (f = 0; f < 16; f++) begin
                xfer(1'b0, 1'b0, 8'h00, 5'(30 + f / 8), 3'(f), 8'h00, 32'h0);
                ex = exp_claim(5'(30 + f / 8), 3'(f), dis);
                check(32'(cl_v), 32'(ex));
                if (!ex)
                    check(rd_v, 32'hffff_ffff);
            end
        end
        wr(8'h40, 32'h0);
        for (i = 0; i < 200; i++) begin
            r = $urandom();
            cat = r[1:0];
            be_v = r[23:20];
            wait_v = {1'b0, r[26:24]};
            bus = (cat == 2'd0) ? 8'h00 : (cat == 2'd1) ? 8'h01 : (cat == 2'd2) ?
                ((r[29:28] == 2'd3) ? 8'h04 : 8'h02 + 8'(r[29:28])) :
                ((r[31:24] < 8'h05) ? 8'h05 : r[31:24]);
            // Reads only, so random traffic never disturbs the bridge setup.
            xfer(1'b0, cat != 2'd0, bus, r[8:4], r[11:9], r[19:12], r);
            ea = exp_addr(cat != 2'd0, bus, r[8:4], r[11:9], r[19:12]);
            ex = (cat == 2'd0) ? exp_claim(r[8:4], r[11:9], 6'h00) : 1'b0;
            check(32'(st_v), 32'(cat != 2'd3));
            if (cat != 2'd3) begin
                check(seen_v.addr, ea);
                check(32'(seen_v.type1), 32'(cat == 2'd2));
                check(32'(seen_v.byte_en), 32'(be_v));
                check(32'(seen_v.write), 32'h0);
            end
            if (cat == 2'd0)
                check(32'(cl_v), 32'(ex));
            if (cat == 2'd3 || (cat == 2'd0 && !ex))
                check(rd_v, 32'hffff_ffff);
            else if (cat != 2'd0)
                check(rd_v, ea ^ 32'ha5a5_5a5a);
        end
        // A second reset in mid-run must bring the status, bus number and scratch registers back to their defaults.
        status_event_in = 1'b1;
        @(negedge clk_in);
        status_event_in = 1'b0;
        nrst_in = 1'b0;
        @(negedge clk_in);
        check({16'h0, sec_bus_out, sub_bus_out}, 32'h0);
        nrst_in = 1'b1;
        @(negedge clk_in);
        rd(8'h04);
        check(rd_v, 32'h0);
        rd(8'h18);
        check(rd_v & 32'h00ff_ff00, 32'h0);
        rd(8'h44);
        check(rd_v, 32'h0);
        report_and_stop();
    end
endmodule
